//--- rtl/spi_port_pkg.sv
// Shared constants, configuration records and state codes of the serial port
`default_nettype none
package spi_port_pkg;
    localparam int WORD_W    = 8;
    localparam int NUM_CS    = 4;
    localparam int CS_W      = 2;
    localparam int DIV_W     = 8;
    localparam int EDGE_W    = $clog2(2 * WORD_W);
    localparam int IDX_W     = $clog2(WORD_W);
    localparam int SYNC_N    = 3;
    localparam int SYNC_MISO = 0;
    localparam int SYNC_NSS  = 1;
    localparam int SYNC_DONE = 2;

    localparam logic [EDGE_W-1:0] LAST_EDGE = EDGE_W'(2 * WORD_W - 1);
    localparam logic [IDX_W-1:0]  LAST_BIT  = IDX_W'(WORD_W - 1);
    localparam logic [DIV_W-1:0]  DIV_ONE   = DIV_W'(1);
    localparam logic [SYNC_N-1:0] SYNC_RST  = 3'h2;

    typedef struct packed {
        logic             clock_polarity;
        logic             clock_phase_bit;
        logic             cs_hold_after_transfer;
        logic [DIV_W-1:0] clock_divisor;
    } cs_cfg_t;

    typedef struct packed {
        logic [CS_W-1:0]   peripheral_select_field;
        logic [WORD_W-1:0] data;
    } spi_word_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SETUP = 4'h2,
        ST_SHIFT = 4'h4,
        ST_DONE  = 4'h8
    } mst_state_t;

    typedef struct packed {
        mst_state_t        state;
        logic              enabled;
        logic              mode_fault;
        logic              tx_empty;
        spi_word_t         tx_buf;
        logic [WORD_W-1:0] sh;
        logic [WORD_W-1:0] rx_sh;
        spi_word_t         rx;
        logic              rx_valid;
        logic [CS_W-1:0]   cur_cs;
        logic [CS_W-1:0]   start_sel;
        logic [NUM_CS-1:0] cs_n;
        logic              cs_oe;
        logic              sck;
        logic              sck_oe;
        logic              mosi;
        logic              mosi_oe;
        logic              miso_oe;
        logic [DIV_W-1:0]  div_cnt;
        logic [EDGE_W-1:0] edge_cnt;
        logic              last_valid;
        logic              last_div1;
        logic [CS_W-1:0]   last_cs;
        logic              slave_run;
        logic              done_seen;
    } ctl_t;

    localparam ctl_t CTL_RST = '{state: ST_IDLE, tx_empty: 1'b1, cs_n: '1, default: '0};
endpackage
`default_nettype wire

//--- rtl/spi_slave_shifter.sv
// Slave-side shift logic clocked by the serial clock from the remote master
`timescale 1ns/1ps
`default_nettype none
module spi_slave_shifter
    import spi_port_pkg::*;
(
    input  wire logic              sck_i,
    input  wire logic              port_rst_n_i,
    input  wire logic              frame_rst_n_i,
    input  wire logic              mosi_i,
    input  wire logic [WORD_W-1:0] tx_word_i,
    output logic                   miso_o,
    output logic [WORD_W-1:0]      rx_word_o,
    output logic                   done_tgl_o
);
    logic [IDX_W-1:0]  bit_cnt_ff;
    logic [IDX_W-1:0]  nxt_bit_cnt;
    logic [IDX_W-1:0]  out_idx_ff;
    logic [WORD_W-1:0] rx_sh_ff;
    logic [WORD_W-1:0] rx_word_ff;
    logic [WORD_W-1:0] nxt_rx_word;
    logic              done_tgl_ff;
    logic              nxt_done_tgl;
    logic              miso_ff;
    logic              word_end;

    // Fixed idle-high timing: data changes on falling edges, captured on rising
    always_comb begin
        word_end     = (bit_cnt_ff == LAST_BIT);
        nxt_bit_cnt  = word_end ? '0 : bit_cnt_ff + IDX_W'(1);
        nxt_rx_word  = word_end ? {rx_sh_ff[WORD_W-2:0], mosi_i} : rx_word_ff;
        nxt_done_tgl = done_tgl_ff ^ word_end;
    end

    // Counters restart whenever the select pin goes inactive
    always_ff @(posedge sck_i or negedge frame_rst_n_i) begin
        if (!frame_rst_n_i) begin
            bit_cnt_ff <= '0;
            rx_sh_ff   <= '0;
        end else begin
            bit_cnt_ff <= nxt_bit_cnt;
            rx_sh_ff   <= {rx_sh_ff[WORD_W-2:0], mosi_i};
        end
    end

    // Toggle must survive frame ends, else the core would miss a word
    always_ff @(posedge sck_i or negedge port_rst_n_i) begin
        if (!port_rst_n_i) begin
            rx_word_ff  <= '0;
            done_tgl_ff <= 1'b0;
        end else begin
            rx_word_ff  <= nxt_rx_word;
            done_tgl_ff <= nxt_done_tgl;
        end
    end

    // Word from the core is quasi-static: software refills between words
    always_ff @(negedge sck_i or negedge frame_rst_n_i) begin
        if (!frame_rst_n_i) begin
            out_idx_ff <= '0;
            miso_ff    <= 1'b0;
        end else begin
            out_idx_ff <= (out_idx_ff == LAST_BIT) ? '0 : out_idx_ff + IDX_W'(1);
            miso_ff    <= tx_word_i[LAST_BIT - out_idx_ff];
        end
    end

    assign miso_o     = miso_ff;
    assign rx_word_o  = rx_word_ff;
    assign done_tgl_o = done_tgl_ff;
endmodule
`default_nettype wire

//--- rtl/spi_port.sv
// Master/slave serial port with chip selects, keeping the known silicon quirks
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1: Chip select 0 hold plus enabled mode-fault detection blocks every transfer start.
// RQ2: Software sets mode_fault_disable before using the port.
// RQ3: Transmit writes while disabled are dropped.
// RQ4: Disable leaves tx_empty_flag alone; a dropped write does not clear it.
// RQ5: DMA words written after disable are lost like any dropped write.
// RQ6: Software stops DMA, waits, then disables; resumes port first, then DMA.
// RQ7: Disable is ignored while in slave mode.
// RQ8: Soft reset clears the whole port; slave is stopped by read then reset.
// RQ9: Polarity 1, phase 0, divisor 1 mixed with other divisor adds an sck pulse.
// RQ10: Software uses divisor 1 on every select when one uses it in that mode.
// RQ11: Returned select field is taken at start, not from pins at end.
// RQ12: Software ignores the returned select field.
// RQ13: Master drives clock and selects, one bit per edge pair per select setup.
module spi_port
    import spi_port_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 ce_i,
    input  wire logic                 port_enable_i,
    input  wire logic                 port_disable_i,
    input  wire logic                 soft_reset_bit_i,
    input  wire logic                 master_mode_i,
    input  wire logic                 mode_fault_disable_i,
    input  wire cs_cfg_t [NUM_CS-1:0] per_cs_config_reg_i,
    input  wire logic                 tx_wr_i,
    input  wire spi_word_t            tx_data_reg_i,
    output logic                      tx_empty_flag_o,
    output spi_word_t                 rx_data_reg_o,
    output logic                      rx_valid_o,
    output logic                      port_enabled_o,
    output logic                      mode_fault_o,
    input  wire logic                 sck_i,
    output logic                      sck_o,
    output logic                      sck_oe_o,
    input  wire logic                 mosi_i,
    output logic                      mosi_o,
    output logic                      mosi_oe_o,
    input  wire logic                 miso_i,
    output logic                      miso_o,
    output logic                      miso_oe_o,
    input  wire logic                 slave_select_n_i,
    output logic [NUM_CS-1:0]         chip_select_pins_n_o,
    output logic                      chip_select_pins_oe_o
);
    logic [1:0]        rst_sync_ff;
    logic              rst_n;
    logic [SYNC_N-1:0] sync_a_ff;
    logic [SYNC_N-1:0] sync_b_ff;
    ctl_t              ctl_ff;
    ctl_t              nxt_ctl;
    cs_cfg_t           new_cfg;
    cs_cfg_t           cur_cfg;
    logic [DIV_W-1:0]  div_lim;
    logic              leading;
    logic              hang;
    logic              extra_pulse;
    logic              nss_s;
    logic              slave_done_tgl;
    logic [WORD_W-1:0] slave_rx_word;
    logic              frame_rst_n;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_a_ff <= SYNC_RST;
            sync_b_ff <= SYNC_RST;
        end else if (ce_i) begin
            sync_a_ff <= {slave_done_tgl, slave_select_n_i, miso_i};
            sync_b_ff <= sync_a_ff;
        end
    end
    assign nss_s = sync_b_ff[SYNC_NSS];

    always_comb begin
        nxt_ctl          = ctl_ff;
        nxt_ctl.rx_valid = 1'b0;
        new_cfg          = per_cs_config_reg_i[ctl_ff.tx_buf.peripheral_select_field];
        cur_cfg          = per_cs_config_reg_i[ctl_ff.cur_cs];
        div_lim          = (cur_cfg.clock_divisor == '0) ? '0 : cur_cfg.clock_divisor - DIV_ONE;
        leading          = ~ctl_ff.edge_cnt[0];
        hang             = per_cs_config_reg_i[0].cs_hold_after_transfer & ~mode_fault_disable_i;
        // Mismatch between this select's divisor-1 status and the previous select's
        extra_pulse      = new_cfg.clock_polarity & ~new_cfg.clock_phase_bit & ctl_ff.last_valid
                         & (ctl_ff.tx_buf.peripheral_select_field != ctl_ff.last_cs)
                         & ((new_cfg.clock_divisor == DIV_ONE) != ctl_ff.last_div1);
        case (ctl_ff.state)
            ST_IDLE: begin
                nxt_ctl.sck = cur_cfg.clock_polarity;
                if (ctl_ff.enabled && master_mode_i && !ctl_ff.tx_empty && !hang) begin // see RQ1
                    nxt_ctl.state     = ST_SETUP;
                    nxt_ctl.tx_empty  = 1'b1;
                    nxt_ctl.cur_cs    = ctl_ff.tx_buf.peripheral_select_field;
                    nxt_ctl.start_sel = ctl_ff.tx_buf.peripheral_select_field; // see RQ11
                    nxt_ctl.cs_n      = ~(NUM_CS'(1) << ctl_ff.tx_buf.peripheral_select_field);
                    nxt_ctl.sck       = new_cfg.clock_polarity ^ extra_pulse; // see RQ9
                    nxt_ctl.div_cnt   = '0;
                    nxt_ctl.edge_cnt  = '0;
                    nxt_ctl.sh        = ctl_ff.tx_buf.data;
                    if (new_cfg.clock_phase_bit) begin
                        // First bit must be on the line before the first edge
                        nxt_ctl.mosi = ctl_ff.tx_buf.data[WORD_W-1];
                        nxt_ctl.sh   = {ctl_ff.tx_buf.data[WORD_W-2:0], 1'b0};
                    end
                end
            end
            ST_SETUP: begin
                nxt_ctl.sck   = cur_cfg.clock_polarity;
                nxt_ctl.state = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (ctl_ff.div_cnt == div_lim) begin // see RQ13
                    nxt_ctl.div_cnt  = '0;
                    nxt_ctl.sck      = ~ctl_ff.sck;
                    nxt_ctl.edge_cnt = ctl_ff.edge_cnt + EDGE_W'(1);
                    if (leading == cur_cfg.clock_phase_bit) begin
                        nxt_ctl.rx_sh = {ctl_ff.rx_sh[WORD_W-2:0], sync_b_ff[SYNC_MISO]};
                    end else begin
                        nxt_ctl.mosi = ctl_ff.sh[WORD_W-1];
                        nxt_ctl.sh   = {ctl_ff.sh[WORD_W-2:0], 1'b0};
                    end
                    if (ctl_ff.edge_cnt == LAST_EDGE) begin
                        nxt_ctl.state = ST_DONE;
                    end
                end else begin
                    nxt_ctl.div_cnt = ctl_ff.div_cnt + DIV_ONE;
                end
            end
            ST_DONE: begin
                nxt_ctl.rx         = '{peripheral_select_field: ctl_ff.start_sel,
                                       data: ctl_ff.rx_sh}; // see RQ11
                nxt_ctl.rx_valid   = 1'b1;
                nxt_ctl.last_valid = 1'b1;
                nxt_ctl.last_cs    = ctl_ff.cur_cs;
                nxt_ctl.last_div1  = (cur_cfg.clock_divisor == DIV_ONE);
                nxt_ctl.state      = ST_IDLE;
                if (!cur_cfg.cs_hold_after_transfer) begin
                    nxt_ctl.cs_n = '1;
                end
            end
            default: begin
                nxt_ctl.state = ST_IDLE;
            end
        endcase

        // Slave word finished in the serial clock domain
        if (sync_b_ff[SYNC_DONE] != ctl_ff.done_seen) begin
            nxt_ctl.done_seen = sync_b_ff[SYNC_DONE];
            if (ctl_ff.slave_run) begin
                nxt_ctl.rx       = '{peripheral_select_field: '0, data: slave_rx_word};
                nxt_ctl.rx_valid = 1'b1;
                nxt_ctl.tx_empty = 1'b1;
            end
        end

        if (port_enable_i) begin
            nxt_ctl.enabled = 1'b1;
        end
        if (port_disable_i && master_mode_i) begin // see RQ7
            nxt_ctl.enabled = 1'b0;
        end
        if (ctl_ff.enabled && master_mode_i && !mode_fault_disable_i && !nss_s) begin
            nxt_ctl.mode_fault = 1'b1;
            nxt_ctl.enabled    = 1'b0;
        end

        // Disable never touches the empty flag; a dropped write leaves it set too
        if (tx_wr_i && ctl_ff.enabled) begin // see RQ3, RQ4, RQ5
            nxt_ctl.tx_buf   = tx_data_reg_i;
            nxt_ctl.tx_empty = 1'b0;
        end

        if (!nxt_ctl.enabled) begin
            nxt_ctl.state = ST_IDLE;
            nxt_ctl.cs_n  = '1;
        end
        nxt_ctl.sck_oe    = nxt_ctl.enabled & master_mode_i;
        nxt_ctl.mosi_oe   = nxt_ctl.enabled & master_mode_i;
        nxt_ctl.cs_oe     = nxt_ctl.enabled & master_mode_i;
        nxt_ctl.slave_run = nxt_ctl.enabled & ~master_mode_i;
        nxt_ctl.miso_oe   = nxt_ctl.enabled & ~master_mode_i & ~nss_s;

        if (soft_reset_bit_i) begin // see RQ8
            nxt_ctl = CTL_RST;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= CTL_RST;
        end else if (ce_i) begin
            ctl_ff <= nxt_ctl;
        end
    end

    // Frame reset follows the select pin directly so the shifter restarts per word
    assign frame_rst_n = ctl_ff.slave_run & ~slave_select_n_i;

    spi_slave_shifter u_slave (
        .sck_i         (sck_i),
        .port_rst_n_i  (ctl_ff.slave_run),
        .frame_rst_n_i (frame_rst_n),
        .mosi_i        (mosi_i),
        .tx_word_i     (ctl_ff.tx_buf.data),
        .miso_o        (miso_o),
        .rx_word_o     (slave_rx_word),
        .done_tgl_o    (slave_done_tgl)
    );

    assign tx_empty_flag_o       = ctl_ff.tx_empty;
    assign rx_data_reg_o         = ctl_ff.rx;
    assign rx_valid_o            = ctl_ff.rx_valid;
    assign port_enabled_o        = ctl_ff.enabled;
    assign mode_fault_o          = ctl_ff.mode_fault;
    assign sck_o                 = ctl_ff.sck;
    assign sck_oe_o              = ctl_ff.sck_oe;
    assign mosi_o                = ctl_ff.mosi;
    assign mosi_oe_o             = ctl_ff.mosi_oe;
    assign miso_oe_o             = ctl_ff.miso_oe;
    assign chip_select_pins_n_o  = ctl_ff.cs_n;
    assign chip_select_pins_oe_o = ctl_ff.cs_oe;
endmodule
`default_nettype wire

//--- tb/spi_port_monitor.sv
// Concurrent checks on the serial port status outputs and chip select pins
`timescale 1ns/1ps
`default_nettype none
module spi_port_monitor
    import spi_port_pkg::*;
(
    input wire logic                 core_clk_i,
    input wire logic                 arst_n_i,
    input wire logic                 ce_i,
    input wire logic                 port_disable_i,
    input wire logic                 soft_reset_bit_i,
    input wire logic                 master_mode_i,
    input wire logic                 mode_fault_disable_i,
    input wire cs_cfg_t [NUM_CS-1:0] per_cs_config_reg_i,
    input wire logic                 tx_wr_i,
    input wire logic                 tx_empty_flag_o,
    input wire logic                 rx_valid_o,
    input wire logic                 port_enabled_o,
    input wire logic                 sck_oe_o,
    input wire logic [NUM_CS-1:0]    chip_select_pins_n_o,
    input wire logic                 chip_select_pins_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    wire logic cs_idle = &chip_select_pins_n_o;

    AST_DROP_KEEPS_EMPTY: assert property (
        ce_i && tx_wr_i && !port_enabled_o && tx_empty_flag_o |=> tx_empty_flag_o)
        else $error("dropped write cleared the empty flag");
    AST_WRITE_TAKEN: assert property (
        ce_i && tx_wr_i && port_enabled_o && !soft_reset_bit_i |=> !tx_empty_flag_o)
        else $error("accepted write left the empty flag set");
    AST_DISABLE_KEEPS_EMPTY: assert property (
        ce_i && port_disable_i && !tx_wr_i && tx_empty_flag_o |=> tx_empty_flag_o)
        else $error("disable changed the empty flag");
    AST_SLAVE_IGNORES_DISABLE: assert property (
        ce_i && port_enabled_o && !master_mode_i && port_disable_i && !soft_reset_bit_i
        |=> port_enabled_o)
        else $error("slave port turned off by disable");
    AST_SOFT_RESET_CLEARS: assert property (
        ce_i && soft_reset_bit_i
        |=> !port_enabled_o && tx_empty_flag_o && cs_idle && !chip_select_pins_oe_o)
        else $error("soft reset left port state behind");
    AST_HOLD_BLOCKS_START: assert property (
        ce_i && per_cs_config_reg_i[0].cs_hold_after_transfer && !mode_fault_disable_i
        && cs_idle |=> cs_idle)
        else $error("transfer started with hold and fault detection on");
    AST_CS_ONE_HOT: assert property (
        !cs_idle |-> $onehot(~chip_select_pins_n_o) && chip_select_pins_oe_o && sck_oe_o)
        else $error("chip selects not one-hot or not driven");
    AST_RX_AFTER_FRAME: assert property (
        ce_i && rx_valid_o && master_mode_i |-> !$past(cs_idle))
        else $error("received word without a preceding frame");
    AST_RX_SINGLE: assert property (
        rx_valid_o |=> !rx_valid_o)
        else $error("received pulse longer than one cycle");
endmodule

bind spi_port spi_port_monitor u_spi_port_monitor (.core_clk_i, .arst_n_i, .ce_i,
    .port_disable_i, .soft_reset_bit_i, .master_mode_i, .mode_fault_disable_i,
    .per_cs_config_reg_i, .tx_wr_i, .tx_empty_flag_o, .rx_valid_o, .port_enabled_o,
    .sck_oe_o, .chip_select_pins_n_o, .chip_select_pins_oe_o);
`default_nettype wire

//--- tb/spi_peer_model.sv
// Behavioural serial slave device answering the port in its master role
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       cs_n_i,
    input  wire logic [7:0] reply_i,
    output logic            miso_o,
    output logic [7:0]      got_o
);
    logic [7:0] sh;
    initial miso_o = 1'b0;
    initial got_o = 8'h00;
    // Rising edge captures, first bit is preloaded when selected
    always @(negedge cs_n_i) begin
        sh = reply_i;
        miso_o = reply_i[7];
    end
    always @(posedge sck_i) if (!cs_n_i) got_o = {got_o[6:0], mosi_i};
    always @(negedge sck_i) if (!cs_n_i) begin
        sh = sh << 1;
        miso_o = sh[7];
    end
    // Released line flips so a stale bit never passes for data
    always @(posedge cs_n_i) miso_o = ~miso_o;
endmodule
`default_nettype wire

//--- tb/spi_master_slave_port_quirks_test.sv
// Self-checking bench for the serial port in master and slave roles
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module spi_master_slave_port_quirks_test
    import spi_port_pkg::*;
;
    logic                 core_clk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1;
    logic                 port_enable_i = 1'b0, port_disable_i = 1'b0, soft_reset_bit_i = 1'b0;
    logic                 master_mode_i = 1'b1, tx_wr_i = 1'b0;
    logic                 mode_fault_disable_i = 1'b1;
    cs_cfg_t [NUM_CS-1:0] per_cs_config_reg_i = '0;
    spi_word_t            tx_data_reg_i = '0;
    logic                 sck_i = 1'b1, mosi_i = 1'b0, slave_select_n_i = 1'b1;
    logic                 miso_i, tx_empty_flag_o, rx_valid_o, port_enabled_o, mode_fault_o;
    logic                 sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    logic                 chip_select_pins_oe_o, sck_q, seen;
    logic [NUM_CS-1:0]    chip_select_pins_n_o;
    spi_word_t            rx_data_reg_o;
    logic [7:0]           peer_reply = 8'h00, peer_got, got = 8'h00;
    int                   err_total = 0, num_checks = 0, edges = 0, cyc_cnt = 0;

    spi_port u_spi_port (.core_clk_i, .arst_n_i, .ce_i, .port_enable_i, .port_disable_i,
        .soft_reset_bit_i, .master_mode_i, .mode_fault_disable_i, .per_cs_config_reg_i,
        .tx_wr_i, .tx_data_reg_i, .tx_empty_flag_o, .rx_data_reg_o, .rx_valid_o,
        .port_enabled_o, .mode_fault_o, .sck_i, .sck_o, .sck_oe_o, .mosi_i, .mosi_o,
        .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o, .slave_select_n_i,
        .chip_select_pins_n_o, .chip_select_pins_oe_o);
    spi_peer_model u_spi_peer_model (.sck_i(sck_o), .mosi_i(mosi_o),
        .cs_n_i(&chip_select_pins_n_o), .reply_i(peer_reply), .miso_o(miso_i),
        .got_o(peer_got));

    always #25 core_clk_i = ~core_clk_i;
    // Serial clock edges are counted only while some select is low
    always @(posedge core_clk_i) begin
        if (!(&chip_select_pins_n_o) && sck_o !== sck_q)
            edges++;
        sck_q <= sck_o;
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic wait_rx();
        seen = 1'b0;
        repeat (300) if (!seen) begin
            @(posedge core_clk_i);
            #1 seen = (rx_valid_o === 1'b1);
        end
        #1;
    endtask
    task automatic send(input logic [1:0] sel, input logic [7:0] d);
        tx_data_reg_i = {sel, d};
        pulse(tx_wr_i);
        wait_rx();
    endtask
    // Remote master frame at the link clock rate, clock still outside it
    task automatic frame(input logic [7:0] d);
        slave_select_n_i = 1'b0;
        #30;
        for (int i = 7; i >= 0; i--) begin
            mosi_i = d[i];
            #1 sck_i = 1'b0;
            #6 got = {got[6:0], miso_o};
            sck_i = 1'b1;
            #5;
        end
        #30 slave_select_n_i = 1'b1;
        mosi_i = ~mosi_i;
    endtask

    task automatic t_master();
        per_cs_config_reg_i[1] = '{1'b0, 1'b1, 1'b0, 8'h04};
        peer_reply = 8'h3C;
        send(2'h1, 8'hA5);
        `CHK("rx pulse", 1'b1, seen)
        `CHK("peer word", 8'hA5, peer_got)
        `CHK("rx word", 8'h3C, rx_data_reg_o.data)
        `CHK("rx select field", 2'h1, rx_data_reg_o.peripheral_select_field)
        `CHK("tx empty", 1'b1, tx_empty_flag_o)
        `CHK("master drives mosi", 2'h2, {mosi_oe_o, miso_oe_o})
        // Feed stops first, then the port is cycled off and on before feeding again
        cyc(2);
        pulse(port_disable_i);
        pulse(port_enable_i);
        send(2'h1, 8'h5C);
        `CHK("word after resume", 8'h5C, peer_got)
        $display("test master transfer done");
    endtask
    task automatic t_hold();
        pulse(port_disable_i);
        tx_data_reg_i = {2'h0, 8'hFF};
        pulse(tx_wr_i);
        `CHK("empty after dropped write", 1'b1, tx_empty_flag_o)
        pulse(port_enable_i);
        mode_fault_disable_i = 1'b0;
        per_cs_config_reg_i[0] = '{1'b0, 1'b1, 1'b1, 8'h04};
        send(2'h0, 8'h5A);
        `CHK("held start", 1'b0, seen)
        `CHK("held selects", 4'hF, chip_select_pins_n_o)
        // Select pin low while detection is on trips the fault and turns the port off
        slave_select_n_i = 1'b0;
        cyc(4);
        `CHK("mode fault", 2'h2, {mode_fault_o, port_enabled_o})
        slave_select_n_i = 1'b1;
        pulse(port_disable_i);
        `CHK("empty after disable", 1'b0, tx_empty_flag_o)
        // A late word as from a channel left running, lost while off
        tx_data_reg_i = {2'h0, 8'h66};
        pulse(tx_wr_i);
        pulse(port_enable_i);
        mode_fault_disable_i = 1'b1;
        wait_rx();
        `CHK("first word kept", 8'h5A, peer_got)
        pulse(soft_reset_bit_i);
        pulse(port_enable_i);
        $display("test hold and disable done");
    endtask
    task automatic t_extra();
        per_cs_config_reg_i[2] = '{1'b1, 1'b0, 1'b0, 8'h01};
        per_cs_config_reg_i[3] = '{1'b1, 1'b0, 1'b0, 8'h04};
        send(2'h3, 8'h11);
        edges = 0;
        send(2'h3, 8'h22);
        `CHK("edges same select", 16, edges)
        edges = 0;
        send(2'h2, 8'h33);
        `CHK("edges mixed divisor", 18, edges)
        per_cs_config_reg_i[3].clock_divisor = 8'h01;
        edges = 0;
        send(2'h3, 8'h44);
        `CHK("edges all divisor one", 16, edges)
        $display("test mixed divisor done");
    endtask
    task automatic t_slave();
        pulse(soft_reset_bit_i);
        master_mode_i = 1'b0;
        pulse(port_enable_i);
        tx_data_reg_i = {2'h0, 8'hC3};
        pulse(tx_wr_i);
        pulse(port_disable_i);
        `CHK("slave stays on", 1'b1, port_enabled_o)
        frame(8'h96);
        cyc(10);
        `CHK("slave rx word", 8'h96, rx_data_reg_o.data)
        `CHK("slave tx word", 8'hC3, got)
        // With the clock enable low even a soft reset must not reach the state
        ce_i = 1'b0;
        pulse(soft_reset_bit_i);
        cyc(1);
        `CHK("reset frozen", 1'b1, port_enabled_o)
        ce_i = 1'b1;
        pulse(soft_reset_bit_i);
        `CHK("slave stopped", 1'b0, port_enabled_o)
        $display("test slave done");
    endtask

    initial begin
        repeat (16) @(posedge core_clk_i);
        #2 arst_n_i = 1'b1;
        cyc(4);
        pulse(port_enable_i);
        t_master();
        t_hold();
        t_extra();
        t_slave();
        final_report();
    end
endmodule
`default_nettype wire
